// >>> rli_device.sv
// Local design decision: register access over a serial frame (sclk, csN, mosi, miso).
`timescale 1ns/100ps
module rli_device #(
	parameter int WAIT_STEP = rli_pkg::WAIT_STEP_CYC,
	parameter int NORESP_STEP = rli_pkg::NORESP_STEP_CYC,
	parameter int TURN_STEP = rli_pkg::TURN_STEP_CYC,
	parameter int NORESP_MAX = rli_pkg::NORESP_MAX_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	rli_link_if.dev link,
	input wire logic directMode,
	input wire logic rxBitValid,
	input wire logic rxBit,
	input wire logic rxError,
	input wire logic txDone,
	input wire logic subI,
	input wire logic subQ,
	input wire logic rxSelQ,
	input wire logic txMod,
	input wire logic anaI,
	input wire logic anaQ,
	input wire logic mixDcA,
	input wire logic mixDcB,
	output logic txStart,
	output rli_pkg::rli_txkind_e txKind,
	output logic [15:0] ackRn16,
	output logic fifoWrite,
	output logic [7:0] fifoData,
	output logic testA,
	output logic testB,
	output logic adcPin,
	output logic rxEnable
);
	typedef enum logic [2:0] {ST_IDLE, ST_TXWAIT, ST_GUARD, ST_LISTEN, ST_RECV,
		ST_TURN} rli_state_e;
	// ----------------------------------------------------------------
	// pin synchronisers and serial frame
	// ----------------------------------------------------------------
	logic [2:0] pinS1, pinS2;
	logic sclkD;
	logic [4:0] bitIdx;
	logic [15:0] shIn;
	logic [7:0] shOut, opByte, rdVal;
	logic misoBit;
	logic [7:0] protReg, turnReg, norespReg, waitReg, measReg, len1Reg, len2Reg;
	logic [5:0] irqFlags, flagSet;
	wire sclkS = pinS2[2];
	wire csS = pinS2[1];
	wire mosiS = pinS2[0];
	wire rise = sclkS & ~sclkD;
	wire fall = ~sclkS & sclkD;
	wire [7:0] firstByte = {shIn[6:0], mosiS};
	wire firstDone = rise & ~csS &
		(bitIdx == rli_pkg::BYTE_BITS - 5'h01);
	wire lastDone = rise & ~csS &
		(bitIdx == rli_pkg::FRAME_BITS - 5'h01);
	wire cmdStb = firstDone & firstByte[rli_pkg::OP_CMD_BIT];
	wire wrStb = lastDone & ~opByte[rli_pkg::OP_CMD_BIT] & ~opByte[rli_pkg::OP_READ_BIT];
	wire rdClr = lastDone & ~opByte[rli_pkg::OP_CMD_BIT] & opByte[rli_pkg::OP_READ_BIT]
		& (opByte[5:0] == rli_pkg::A_IRQ1);
	wire [11:0] lenReg = {len1Reg[3:0], len2Reg};
	wire lenWr = wrStb & (opByte[5:0] == rli_pkg::A_LEN1 || opByte[5:0] == rli_pkg::A_LEN2);
	wire [11:0] lenWrVal = (opByte[5:0] == rli_pkg::A_LEN1) ?
		{firstByte[3:0], len2Reg} : {len1Reg[3:0], firstByte};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pinS1 <= 3'h2;
			pinS2 <= 3'h2;
			sclkD <= 1'b0;
		end else begin
			pinS1 <= {link.sclk, link.csN, link.mosi};
			pinS2 <= pinS1;
			sclkD <= pinS2[2];
		end
	end

	always_comb begin
		case (opByte[5:0])
			rli_pkg::A_PROT: rdVal = protReg;
			rli_pkg::A_TURN: rdVal = turnReg;
			rli_pkg::A_NORESP: rdVal = norespReg;
			rli_pkg::A_WAIT: rdVal = waitReg;
			rli_pkg::A_MEAS: rdVal = measReg;
			rli_pkg::A_IRQ1: rdVal = {2'h0, irqFlags};
			rli_pkg::A_LEN1: rdVal = len1Reg;
			rli_pkg::A_LEN2: rdVal = len2Reg;
			default: rdVal = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bitIdx <= 5'h00;
			shIn <= 16'h0000;
			shOut <= 8'h00;
			opByte <= 8'h00;
			misoBit <= 1'b0;
		end else if (csS) begin
			bitIdx <= 5'h00;
		end else begin
			if (rise) begin
				shIn <= {shIn[14:0], mosiS};
				bitIdx <= bitIdx + 5'h01;
			end
			if (firstDone) begin
				opByte <= firstByte;
			end
			if (fall && bitIdx == rli_pkg::BYTE_BITS) begin
				misoBit <= rdVal[7];
				shOut <= {rdVal[6:0], 1'b0};
			end else if (fall && bitIdx > rli_pkg::BYTE_BITS) begin
				misoBit <= shOut[7];
				shOut <= {shOut[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// registers and interrupt flags
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			protReg <= 8'h00;
			turnReg <= 8'h00;
			norespReg <= 8'h00;
			waitReg <= 8'h00;
			measReg <= 8'h00;
			len1Reg <= 8'h00;
			len2Reg <= 8'h00;
		end else if (wrStb) begin
			case (opByte[5:0])
				rli_pkg::A_PROT: protReg <= firstByte;
				rli_pkg::A_TURN: turnReg <= firstByte;
				rli_pkg::A_NORESP: norespReg <= firstByte;
				rli_pkg::A_WAIT: waitReg <= firstByte;
				rli_pkg::A_MEAS: measReg <= firstByte;
				rli_pkg::A_LEN1: len1Reg <= firstByte;
				rli_pkg::A_LEN2: len2Reg <= firstByte;
				default: ;
			endcase
		end
	end

	// set wins over the clear-on-read
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irqFlags <= 6'h00;
		end else begin
			irqFlags <= (rdClr ? 6'h00 : irqFlags) | flagSet;
		end
	end

	// ----------------------------------------------------------------
	// sequence, timers and reception
	// ----------------------------------------------------------------
	rli_state_e st;
	rli_pkg::rli_rxkind_e kind;
	logic [21:0] tmr;
	logic [11:0] expLen, bitCnt;
	logic [8:0] byteCnt;
	logic [7:0] byteSh;
	logic [15:0] rnSh;
	logic seqOn, ackSent;
	wire secondEn = len1Reg[rli_pkg::LEN1_SECOND_BIT];
	wire repeatEn = len1Reg[rli_pkg::LEN1_REPEAT_BIT];
	wire [1:0] invSel = protReg[rli_pkg::PROT_INV_LO +: 2];
	wire [7:0] newByte = {byteSh[6:0], rxBit};
	wire [11:0] bitNext = bitCnt + 12'h001;
	wire [8:0] byteNext = byteCnt + 9'h001;
	wire [21:0] waitCyc = 22'(waitReg * WAIT_STEP);
	wire [21:0] turnCyc = 22'(turnReg * TURN_STEP);
	wire [21:0] norespCyc = (norespReg == rli_pkg::NORESP_FIXED) ?
		22'(NORESP_MAX) : 22'(norespReg * NORESP_STEP);
	wire nextAck = seqOn && kind == rli_pkg::RK_RN16 && invSel != rli_pkg::INV_QUERY;
	wire nextReq = seqOn && kind == rli_pkg::RK_EPC && invSel == rli_pkg::INV_REQRN;
	wire inRx = st == ST_LISTEN || st == ST_RECV;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= ST_IDLE;
			kind <= rli_pkg::RK_REGS;
			tmr <= 22'h000000;
			expLen <= 12'h000;
			bitCnt <= 12'h000;
			byteCnt <= 9'h000;
			byteSh <= 8'h00;
			rnSh <= 16'h0000;
			ackRn16 <= 16'h0000;
			txStart <= 1'b0;
			txKind <= rli_pkg::TXK_NORMAL;
			fifoWrite <= 1'b0;
			fifoData <= 8'h00;
			flagSet <= 6'h00;
			seqOn <= 1'b0;
			ackSent <= 1'b0;
		end else begin
			txStart <= 1'b0;
			fifoWrite <= 1'b0;
			flagSet <= 6'h00;
			if (lenWr && (kind != rli_pkg::RK_EPC ||
				byteCnt >= rli_pkg::SECOND_BYTE)) begin
				expLen <= lenWrVal;
			end
			if (cmdStb && firstByte == rli_pkg::C_BLOCK_RX) begin
				st <= ST_IDLE;
			end else begin
				case (st)
					ST_IDLE: if (cmdStb) begin
						bitCnt <= 12'h000;
						byteCnt <= 9'h000;
						if (firstByte >= rli_pkg::C_TX_FIRST && firstByte <= rli_pkg::C_TX_LAST) begin
							st <= ST_TXWAIT;
							txStart <= 1'b1;
							txKind <= rli_pkg::TXK_NORMAL;
							kind <= rli_pkg::RK_REGS;
							expLen <= lenReg;
							seqOn <= 1'b0;
						end else if (firstByte >= rli_pkg::C_QUERY_FIRST &&
							firstByte <= rli_pkg::C_QUERY_LAST) begin
							st <= ST_TXWAIT;
							txStart <= 1'b1;
							txKind <= rli_pkg::TXK_QUERY;
							kind <= rli_pkg::RK_RN16;
							expLen <= rli_pkg::LEN_RN16;
							seqOn <= 1'b1;
							ackSent <= 1'b0;
						end else if (firstByte == rli_pkg::C_REQ_RN) begin
							st <= ST_TXWAIT;
							txStart <= 1'b1;
							txKind <= rli_pkg::TXK_REQRN;
							kind <= rli_pkg::RK_HANDLE;
							expLen <= rli_pkg::LEN_HANDLE;
							seqOn <= 1'b0;
						end else if (firstByte == rli_pkg::C_ENABLE_RX) begin
							st <= ST_LISTEN;
							tmr <= norespCyc;
							kind <= rli_pkg::RK_REGS;
							expLen <= lenReg;
							seqOn <= 1'b0;
						end
					end
					ST_TXWAIT: if (txDone) begin
						st <= ST_GUARD;
						tmr <= waitCyc;
					end
					ST_GUARD: if (tmr == 22'h000000) begin
						st <= ST_LISTEN;
						tmr <= norespCyc;
					end else begin
						tmr <= tmr - 22'h000001;
					end
					ST_LISTEN, ST_RECV: begin
						if (tmr != 22'h000000) begin
							tmr <= tmr - 22'h000001;
						end
						if (st == ST_LISTEN && tmr == 22'h000000 && !rxBitValid) begin
							st <= ST_IDLE;
							flagSet[rli_pkg::IRQ_NORESP] <= 1'b1;
							flagSet[rli_pkg::IRQ_SEQ] <= seqOn & ackSent;
						end else if (rxError) begin
							st <= ST_IDLE;
							flagSet[rli_pkg::IRQ_ERR] <= 1'b1;
							flagSet[rli_pkg::IRQ_SEQ] <= seqOn & ackSent;
						end else if (rxBitValid) begin
							st <= ST_RECV;
							bitCnt <= bitNext;
							byteSh <= newByte;
							rnSh <= {rnSh[14:0], rxBit};
							if (bitCnt == 12'h000 && rxBit && len1Reg[rli_pkg::LEN1_ERRLEN_BIT]) begin
								expLen <= rli_pkg::LEN_ERRCODE;
							end
							if (bitCnt[2:0] == 3'h7) begin
								byteCnt <= byteNext;
								fifoData <= newByte;
								fifoWrite <= secondEn || kind == rli_pkg::RK_RN16 ||
									(kind == rli_pkg::RK_EPC && byteCnt == 9'h000) ||
									bitNext + rli_pkg::CRC_BITS <= expLen;
								if (kind == rli_pkg::RK_EPC && byteCnt == 9'h000) begin
									expLen <= rli_pkg::LEN_PC_CRC + {3'h0, byteSh[6:2], 4'h0};
								end
								if (secondEn && (byteNext == rli_pkg::SECOND_BYTE ||
									(repeatEn && byteNext > rli_pkg::SECOND_BYTE &&
									!byteNext[0]))) begin
									flagSet[rli_pkg::IRQ_SECOND] <= 1'b1;
								end
								if (kind == rli_pkg::RK_EPC &&
									byteNext == rli_pkg::FIFO_IRQ_BYTES) begin
									flagSet[rli_pkg::IRQ_FIFO] <= 1'b1;
								end
							end
							if (bitNext == expLen) begin
								if (kind == rli_pkg::RK_RN16) begin
									ackRn16 <= {rnSh[14:0], rxBit};
								end
								flagSet[rli_pkg::IRQ_RX] <= ~nextAck;
								if (nextAck || nextReq) begin
									st <= ST_TURN;
									tmr <= turnCyc;
								end else begin
									st <= ST_IDLE;
									flagSet[rli_pkg::IRQ_SEQ] <= seqOn & ackSent;
								end
							end
						end
					end
					ST_TURN: if (tmr == 22'h000000) begin
						st <= ST_TXWAIT;
						txStart <= 1'b1;
						bitCnt <= 12'h000;
						byteCnt <= 9'h000;
						if (kind == rli_pkg::RK_RN16) begin
							txKind <= rli_pkg::TXK_ACK;
							kind <= rli_pkg::RK_EPC;
							expLen <= rli_pkg::LEN_PC;
							ackSent <= 1'b1;
						end else begin
							txKind <= rli_pkg::TXK_REQRN;
							kind <= rli_pkg::RK_HANDLE;
							expLen <= rli_pkg::LEN_HANDLE;
						end
					end else begin
						tmr <= tmr - 22'h000001;
					end
					default: st <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// pin routing and test outputs
	// ----------------------------------------------------------------
	wire [1:0] tcomb = measReg[rli_pkg::MEAS_TCOMB_LO +: 2];
	wire [1:0] anaSel = measReg[rli_pkg::MEAS_ANA_LO +: 2];
	wire rawSel = protReg[rli_pkg::PROT_RAW_BIT];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			link.miso <= 1'b0;
			link.irq <= 1'b0;
			rxEnable <= 1'b0;
			testA <= 1'b0;
			testB <= 1'b0;
			adcPin <= 1'b0;
		end else begin
			if (directMode) begin
				link.miso <= rawSel ? subI : rxBit;
				link.irq <= rawSel ? subQ : rxBitValid;
			end else begin
				link.miso <= misoBit;
				link.irq <= |irqFlags;
			end
			rxEnable <= directMode ? sclkS : (st == ST_GUARD || inRx);
			adcPin <= (tcomb == rli_pkg::TC_RXEN) & rxEnable;
			if (tcomb == rli_pkg::TC_IQ) begin
				testA <= subI;
				testB <= subQ;
			end else if (tcomb == rli_pkg::TC_TXRX) begin
				testA <= txMod;
				testB <= rxSelQ ? subQ : subI;
			end else if (anaSel == rli_pkg::AN_SUB) begin
				testA <= anaI;
				testB <= anaQ;
			end else if (anaSel == rli_pkg::AN_MIX) begin
				testA <= mixDcA;
				testB <= mixDcB;
			end else begin
				testA <= 1'b0;
				testB <= 1'b0;
			end
		end
	end
endmodule

// >>> rli_pkg.sv
package rli_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int SCLK_NS = 160;
	localparam int HALF_CYC = SCLK_NS / (2 * CLK_NS);
	localparam int WAIT_STEP_NS = 6400;
	localparam int NORESP_STEP_NS = 25600;
	localparam int TURN_STEP_NS = 800;
	localparam int NORESP_MAX_NS = 26200000;
	localparam int WAIT_STEP_CYC = WAIT_STEP_NS / CLK_NS;
	localparam int NORESP_STEP_CYC = NORESP_STEP_NS / CLK_NS;
	localparam int TURN_STEP_CYC = TURN_STEP_NS / CLK_NS;
	localparam int NORESP_MAX_CYC = NORESP_MAX_NS / CLK_NS;
	localparam logic [7:0] NORESP_FIXED = 8'hff;
	// ----------------------------------------------------------------
	// device register addresses
	// ----------------------------------------------------------------
	localparam logic [5:0] A_PROT = 6'h01;
	localparam logic [5:0] A_TURN = 6'h06;
	localparam logic [5:0] A_NORESP = 6'h07;
	localparam logic [5:0] A_WAIT = 6'h08;
	localparam logic [5:0] A_MEAS = 6'h10;
	localparam logic [5:0] A_IRQ1 = 6'h37;
	localparam logic [5:0] A_LEN1 = 6'h3a;
	localparam logic [5:0] A_LEN2 = 6'h3b;
	// ----------------------------------------------------------------
	// direct commands and frame layout
	// ----------------------------------------------------------------
	localparam logic [7:0] C_TX_FIRST = 8'h90;
	localparam logic [7:0] C_TX_LAST = 8'h92;
	localparam logic [7:0] C_BLOCK_RX = 8'h96;
	localparam logic [7:0] C_ENABLE_RX = 8'h97;
	localparam logic [7:0] C_QUERY_FIRST = 8'h98;
	localparam logic [7:0] C_QUERY_LAST = 8'h9c;
	localparam logic [7:0] C_REQ_RN = 8'h9f;
	localparam int OP_CMD_BIT = 7;
	localparam int OP_READ_BIT = 6;
	localparam logic [4:0] BYTE_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	// ----------------------------------------------------------------
	// fields
	// ----------------------------------------------------------------
	localparam int PROT_RAW_BIT = 6;
	localparam int PROT_INV_LO = 4;
	localparam int LEN1_SECOND_BIT = 7;
	localparam int LEN1_REPEAT_BIT = 6;
	localparam int LEN1_ERRLEN_BIT = 5;
	localparam int MEAS_TCOMB_LO = 4;
	localparam int MEAS_ANA_LO = 6;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_SECOND = 1;
	localparam int IRQ_FIFO = 2;
	localparam int IRQ_RX = 3;
	localparam int IRQ_SEQ = 4;
	localparam int IRQ_NORESP = 5;
	localparam logic [1:0] INV_QUERY = 2'h0;
	localparam logic [1:0] INV_ACK = 2'h1;
	localparam logic [1:0] INV_REQRN = 2'h2;
	localparam logic [1:0] TC_IQ = 2'h1;
	localparam logic [1:0] TC_TXRX = 2'h2;
	localparam logic [1:0] TC_RXEN = 2'h3;
	localparam logic [1:0] AN_SUB = 2'h1;
	localparam logic [1:0] AN_MIX = 2'h2;
	// ----------------------------------------------------------------
	// reception lengths in bits, FIFO and second-byte thresholds in bytes
	// ----------------------------------------------------------------
	localparam logic [11:0] LEN_RN16 = 12'h010;
	localparam logic [11:0] LEN_PC = 12'h010;
	localparam logic [11:0] LEN_HANDLE = 12'h020;
	localparam logic [11:0] LEN_ERRCODE = 12'h029;
	localparam logic [11:0] LEN_PC_CRC = 12'h020;
	localparam logic [11:0] CRC_BITS = 12'h010;
	localparam logic [8:0] FIFO_IRQ_BYTES = 9'h013;
	localparam logic [8:0] SECOND_BYTE = 9'h002;
	// ----------------------------------------------------------------
	// host register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] H_CMD = 8'h00;
	localparam logic [7:0] H_STATUS = 8'h04;
	localparam logic [7:0] H_DIRECT = 8'h08;
	typedef enum logic [1:0] {TXK_NORMAL, TXK_QUERY, TXK_ACK, TXK_REQRN} rli_txkind_e;
	typedef enum logic [1:0] {RK_REGS, RK_RN16, RK_EPC, RK_HANDLE} rli_rxkind_e;
endpackage

// >>> rli_link_if.sv
`timescale 1ns/100ps
interface rli_link_if;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;
	logic irq;
	modport dev (input sclk, input csN, input mosi, output miso, output irq);
	modport host (output sclk, output csN, output mosi, input miso, input irq);
endinterface

// >>> rli_host.sv
`timescale 1ns/100ps
module rli_host #(
	parameter int HALF = rli_pkg::HALF_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	rli_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} rli_hstate_e;
	// ----------------------------------------------------------------
	// synchronisers and apb slave
	// ----------------------------------------------------------------
	logic [1:0] inS1, inS2;
	logic busy, dirRx;
	logic [7:0] rdData;
	rli_hstate_e st;
	wire misoS = inS2[1];
	wire irqS = inS2[0];
	wire acc = psel & penable & pready;
	wire start = acc & pwrite & (paddr == rli_pkg::H_CMD) & ~busy;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			inS1 <= 2'h0;
			inS2 <= 2'h0;
		end else begin
			inS1 <= {link.miso, link.irq};
			inS2 <= inS1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			dirRx <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel && penable && !pready) begin
				case (paddr)
					rli_pkg::H_STATUS: prdata <= {16'h0000, rdData, 6'h00, irqS, busy};
					rli_pkg::H_DIRECT: prdata <= {31'h00000000, dirRx};
					default: prdata <= 32'h00000000;
				endcase
			end
			if (acc && pwrite && paddr == rli_pkg::H_DIRECT) begin
				dirRx <= pwdata[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// serial frame engine
	// ----------------------------------------------------------------
	logic [15:0] sh;
	logic [4:0] nBits, bitN;
	logic [7:0] cnt;
	wire cntZero = cnt == 8'h00;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= HS_IDLE;
			busy <= 1'b0;
			sh <= 16'h0000;
			nBits <= 5'h00;
			bitN <= 5'h00;
			cnt <= 8'h00;
			rdData <= 8'h00;
			link.sclk <= 1'b0;
			link.csN <= 1'b1;
			link.mosi <= 1'b0;
		end else begin
			if (!cntZero) begin
				cnt <= cnt - 8'h01;
			end
			case (st)
				HS_IDLE: begin
					link.sclk <= dirRx;
					if (start) begin
						busy <= 1'b1;
						sh <= {pwdata[7:0], pwdata[15:8]};
						nBits <= pwdata[rli_pkg::OP_CMD_BIT] ? rli_pkg::BYTE_BITS : rli_pkg::FRAME_BITS;
						link.mosi <= pwdata[7];
						link.csN <= 1'b0;
						link.sclk <= 1'b0;
						bitN <= 5'h00;
						cnt <= 8'(HALF - 1);
						st <= HS_LOW;
					end
				end
				HS_LOW: if (cntZero) begin
					link.sclk <= 1'b1;
					if (bitN >= rli_pkg::BYTE_BITS) begin
						rdData <= {rdData[6:0], misoS};
					end
					cnt <= 8'(HALF - 1);
					st <= HS_HIGH;
				end
				HS_HIGH: if (cntZero) begin
					link.sclk <= 1'b0;
					bitN <= bitN + 5'h01;
					sh <= {sh[14:0], 1'b0};
					link.mosi <= sh[14];
					cnt <= 8'(HALF - 1);
					st <= (bitN + 5'h01 == nBits) ? HS_GAP : HS_LOW;
				end
				HS_GAP: if (cntZero) begin
					if (link.csN) begin
						busy <= 1'b0;
						st <= HS_IDLE;
					end else begin
						link.csN <= 1'b1;
						cnt <= 8'(HALF - 1);
					end
				end
				default: st <= HS_IDLE;
			endcase
		end
	end
endmodule

// >>> rli_assertions.sv
`timescale 1ns/100ps
module rli_assertions (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic miso,
	input wire logic irq
);
	// ----------------------------------------------------------------
	// serial frame checks
	// ----------------------------------------------------------------
	logic [4:0] rises;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rises <= 5'h00;
		end else if (csN) begin
			rises <= 5'h00;
		end else if ($rose(sclk)) begin
			rises <= rises + 5'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence lowHalf;
		!sclk [*8];
	endsequence
	sequence highHalf;
		sclk [*8];
	endsequence
	AST_FRAME_START: assert property ($fell(csN) |-> lowHalf ##[1:4] sclk)
		else $error("first clock edge misplaced");
	AST_SCLK_HIGH: assert property ($rose(sclk) && !csN |=> highHalf)
		else $error("clock high phase short");
	AST_SCLK_LOW: assert property ($fell(sclk) && !csN |=> lowHalf)
		else $error("clock low phase short");
	AST_MOSI_HOLD: assert property ($rose(sclk) && !csN |=> $stable(mosi) [*8])
		else $error("data moved while clock high");
	AST_FRAME_LEN: assert property ($fell(csN) |-> ##[150:400] $rose(csN))
		else $error("frame length out of range");
	AST_FRAME_BITS: assert property ($rose(csN) |->
		rises == rli_pkg::BYTE_BITS || rises == rli_pkg::FRAME_BITS)
		else $error("frame bit count wrong");
	AST_GAP: assert property ($rose(csN) |-> csN [*8])
		else $error("frame gap short");
	AST_END_LOW: assert property ($rose(csN) |-> !sclk && !$past(sclk, 8))
		else $error("clock not idle at frame end");
endmodule

// >>> rfid_rx_length_and_auto_inventory_test.sv
`timescale 1ns/100ps
module rfid_rx_length_and_auto_inventory_test;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, directMode = 1'b0, rxBitValid = 1'b0;
	logic rxBit = 1'b0, txDone = 1'b0, subI = 1'b0, subQ = 1'b0;
	logic txMod = 1'b0, mixDcA = 1'b0, pready, txStart, fifoWrite;
	logic rxError = 1'b0, rxSelQ = 1'b0, anaI = 1'b0, anaQ = 1'b0;
	logic mixDcB = 1'b0;
	logic testA, testB, adcPin, rxEnable;
	logic [7:0] paddr = 8'h00, fifoData, lastFifo;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] ackRn16;
	rli_pkg::rli_txkind_e txKind;
	int fail_count = 0, compares = 0, nFifo = 0, nTx = 0, seenTx = 0;
	rli_link_if link();
	rli_host u_rli_host (.core_clk, .rstn, .link(link), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr());
	rli_device #(.WAIT_STEP(4), .NORESP_STEP(8), .TURN_STEP(2),
		.NORESP_MAX(50)) u_rli_device (.core_clk, .rstn, .link(link),
		.directMode, .rxBitValid, .rxBit, .rxError, .txDone, .subI,
		.subQ, .rxSelQ, .txMod, .anaI, .anaQ, .mixDcA,
		.mixDcB, .txStart, .txKind, .ackRn16, .fifoWrite, .fifoData,
		.testA, .testB, .adcPin, .rxEnable);
	rli_assertions u_rli_assertions (.core_clk, .rstn, .sclk(link.sclk),
		.csN(link.csN), .mosi(link.mosi), .miso(link.miso), .irq(link.irq));
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (fifoWrite === 1'b1) nFifo++;
		if (fifoWrite === 1'b1) lastFifo <= fifoData;
		if (txStart === 1'b1) nTx++;
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task dev(input logic [15:0] v);
		apb(1'b1, rli_pkg::H_CMD, {16'h0, v});
		do apb(1'b0, rli_pkg::H_STATUS, 32'h0); while (rd[0] !== 1'b0);
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		dev({d, 2'h0, a});
	endtask
	task rdReg(input logic [5:0] a, input logic [7:0] exp);
		dev({8'h00, 2'h1, a});
		chk(rd[15:8], exp);
	endtask
	task step(input logic [15:0] kind);
		for (int i = 0; i < 5000 && nTx <= seenTx; i++) @(posedge core_clk);
		chk(16'(nTx > seenTx), 16'h0001);
		seenTx = nTx;
		chk(txKind, kind);
		@(posedge core_clk) txDone <= 1'b1;
		@(posedge core_clk) txDone <= 1'b0;
		repeat (10) @(posedge core_clk);
	endtask
	task bits(input int n, input logic [63:0] v);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk) begin rxBitValid <= 1'b1; rxBit <= v[i]; end
			@(posedge core_clk) rxBitValid <= 1'b0;
		end
		repeat (20) @(posedge core_clk);
	endtask
	task print_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#600000;
		fail_count++;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		rdReg(rli_pkg::A_LEN1, 8'h00);
		rdReg(rli_pkg::A_PROT, 8'h00);
		wr(rli_pkg::A_WAIT, 8'h01);
		wr(rli_pkg::A_NORESP, 8'h10);
		wr(rli_pkg::A_TURN, 8'h01);
		dev({8'h00, rli_pkg::C_QUERY_FIRST});
		step(rli_pkg::TXK_QUERY);
		bits(16, 64'ha5c3);
		chk(ackRn16, 16'ha5c3);
		rdReg(rli_pkg::A_IRQ1, 8'h08);
		$display("query only test done");
		for (int m = 1; m <= 2; m++) begin
			wr(rli_pkg::A_PROT, 8'(m << 4));
			dev({8'h00, rli_pkg::C_QUERY_LAST});
			step(rli_pkg::TXK_QUERY);
			bits(16, 64'h1234);
			step(rli_pkg::TXK_ACK);
			chk(ackRn16, 16'h1234);
			nFifo = 0;
			bits(48, 64'h0800_1111_2222);
			if (m == 2) begin
				step(rli_pkg::TXK_REQRN);
				bits(32, 64'h5566_7788);
			end
			chk(16'(nFifo), (m == 2) ? 16'h6 : 16'h4);
			rdReg(rli_pkg::A_IRQ1, 8'h18);
			$display("auto inventory test done");
		end
		wr(rli_pkg::A_PROT, 8'h00);
		dev({8'h00, rli_pkg::C_QUERY_FIRST});
		step(rli_pkg::TXK_QUERY);
		repeat (300) @(posedge core_clk);
		rdReg(rli_pkg::A_IRQ1, 8'h20);
		dev({8'h00, rli_pkg::C_QUERY_FIRST});
		step(rli_pkg::TXK_QUERY);
		rxError <= 1'b1;
		@(posedge core_clk) rxError <= 1'b0;
		rdReg(rli_pkg::A_IRQ1, 8'h01);
		$display("empty slot test done");
		wr(rli_pkg::A_LEN1, 8'hc0);
		wr(rli_pkg::A_LEN2, 8'h30);
		nFifo = 0;
		dev({8'h00, rli_pkg::C_TX_FIRST});
		step(rli_pkg::TXK_NORMAL);
		bits(16, 64'h0102);
		apb(1'b0, rli_pkg::H_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		rdReg(rli_pkg::A_IRQ1, 8'h02);
		bits(16, 64'h0304);
		rdReg(rli_pkg::A_IRQ1, 8'h02);
		wr(rli_pkg::A_LEN1, 8'h80);
		wr(rli_pkg::A_LEN2, 8'h38);
		bits(16, 64'h0506);
		rdReg(rli_pkg::A_IRQ1, 8'h00);
		bits(8, 64'h07);
		chk(16'(nFifo), 16'h7);
		chk(lastFifo, 16'h0007);
		rdReg(rli_pkg::A_IRQ1, 8'h08);
		wr(rli_pkg::A_LEN1, 8'h20);
		wr(rli_pkg::A_LEN2, 8'h10);
		dev({8'h00, rli_pkg::C_TX_LAST});
		step(rli_pkg::TXK_NORMAL);
		bits(16, 64'h8000);
		rdReg(rli_pkg::A_IRQ1, 8'h00);
		bits(25, 64'h1);
		rdReg(rli_pkg::A_IRQ1, 8'h08);
		wr(rli_pkg::A_LEN2, 8'h08);
		dev({8'h00, rli_pkg::C_ENABLE_RX});
		bits(8, 64'h5a);
		rdReg(rli_pkg::A_IRQ1, 8'h08);
		$display("length test done");
		subI <= 1'b1;
		anaQ <= 1'b1;
		wr(rli_pkg::A_MEAS, 8'h50);
		chk({testA, testB}, 2'h2);
		wr(rli_pkg::A_MEAS, 8'h20);
		chk({testA, testB}, 2'h1);
		rxSelQ <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(testB, 1'b0);
		mixDcA <= 1'b1;
		mixDcB <= 1'b1;
		wr(rli_pkg::A_MEAS, 8'h80);
		chk({testA, testB}, 2'h3);
		wr(rli_pkg::A_PROT, 8'h40);
		directMode <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk({link.miso, link.irq}, 2'h2);
		wr(rli_pkg::A_PROT, 8'h00);
		wr(rli_pkg::A_MEAS, 8'h30);
		rxBit <= 1'b1;
		rxBitValid <= 1'b1;
		apb(1'b1, rli_pkg::H_DIRECT, 32'h1);
		repeat (8) @(posedge core_clk);
		chk({link.miso, link.irq}, 2'h3);
		chk({rxEnable, adcPin}, 2'h3);
		rxBitValid <= 1'b0;
		$display("routing test done");
		print_verdict;
	end
endmodule
